/* hdl/acs_adc_control.sv */
// Contract
// - Sample timing independent of processor oscillator
// - Convert continuously while enable bit set
// - Hardware start-up wait after enabling
// - Discard one conversion after enable/config write
// - Processor clock switch also forces discard
// - First result: start-up plus doubled time
// - Config write never halts the DMA
// - Overrun flag when result, DMA idle
// - Clip flag when gain product overflows
// - Full flag on last buffer location
// - Half flag on last lower-half location
// - Writing one clears a status flag
// - Status flags at bits 4..1
// - Enable bits 4..1 gate interrupt
// - Clamp clipped result to extremes
// - Config bit 0 starts/stops conversions
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module acs_adc_control (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic [15:0] convData,
	input  wire logic        cpuClkSel,
	output logic             analogOn,
	output logic             convDone,
	output logic             dmaWrValid,
	output logic [12:0]      dmaWrAddr,
	output logic [15:0]      dmaWrData,
	output logic             irq
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		acs_pkg::acs_seq_t seq;      // Sequencer state
		logic [9:0]        warmCnt;  // Start-up wait counter
		logic [4:0]        tickCnt;  // Sample clock divider
		logic [12:0]       smpCnt;   // Sample clocks in conversion
		logic              discard;  // Next conversion is thrown away
		logic              clkPrev;  // Last seen oscillator select
		logic [15:0]       cfg;      // Configuration register
		logic [15:0]       offset;   // Offset correction
		logic [15:0]       gain;     // Gain correction
		logic [3:0]        evEn;     // Event mask
		logic [3:0]        evSts;    // Event flags
		logic              wrap;     // Circular buffer select
		logic              dmaAct;   // DMA running
		logic              result_overrun_flag;   // DMA overflow status
		logic [12:0]       base;     // Buffer base pointer
		logic [12:0]       count;    // Buffer sample count
		logic [12:0]       idx;      // Samples written so far
		logic              wrValid;  // DMA write strobe
		logic [12:0]       wrAddr;   // DMA byte address
		logic [15:0]       wrData;   // DMA write data
		logic              done;     // Delivered result pulse
		logic              ready;    // APB ready
		logic [31:0]       rdata;    // APB read data
		logic              err;      // APB error
	} acs_state_t;

	acs_state_t q;          // Registered state
	acs_state_t d;          // Next state

	logic              acc;       // Access phase
	logic              wr;        // Write takes effect
	logic              hit;       // Address decodes
	logic [31:0]       rmux;      // Read mux
	logic              cfgWr;     // Config write this cycle
	logic              restart;   // Config or clock change while running
	logic              tickLast;  // Last system clock of a sample clock
	logic [4:0]        divLast;   // Divider terminal count
	logic [12:0]       convLast;  // Last sample clock of a conversion
	logic              convEnd;   // Conversion finished
	logic              resRdy;    // Result to deliver
	logic signed [16:0] sum;      // Offset-corrected value
	logic signed [33:0] prod;     // Gain product
	logic signed [18:0] scaled;   // Product back at integer scale
	logic [15:0]       corr;      // Clamped result
	logic              clip;      // Product out of range
	logic [3:0]        evSet;     // Flags raised this cycle
	logic [3:0]        evClr;     // Flags cleared by software
	logic [12:0]       halfLast;  // Index of last lower-half sample
	logic [12:0]       idxNext;   // Index after this write

	// ****************************************
	// Next-state logic
	// ****************************************
	// One process for bus, sequencer, correction and DMA
	always_comb begin
		d        = q;
		d.wrValid = 1'b0;
		d.done    = 1'b0;
		evSet    = 4'h0;
		evClr    = 4'h0;
		resRdy   = 1'b0;
		convEnd  = 1'b0;
		// Bus decode
		acc   = psel && penable;
		wr    = acc && q.ready && pwrite;
		hit   = 1'b1;
		rmux  = 32'h0000_0000;
		case (paddr)
			acs_pkg::OFS_STATUS:  rmux[acs_pkg::EV_MSB:acs_pkg::EV_LSB] = q.evSts;
			acs_pkg::OFS_ENABLE:  rmux[acs_pkg::EV_MSB:acs_pkg::EV_LSB] = q.evEn;
			acs_pkg::OFS_CONFIG:  rmux[15:0] = q.cfg;
			acs_pkg::OFS_OFFSET:  rmux[15:0] = q.offset;
			acs_pkg::OFS_GAIN:    rmux[15:0] = q.gain;
			acs_pkg::OFS_DMA_CTL: rmux[acs_pkg::DMA_WRAP] = q.wrap;
			acs_pkg::OFS_DMA_STS: begin
				rmux[acs_pkg::STS_ACT] = q.dmaAct;
				rmux[acs_pkg::STS_OVF] = q.result_overrun_flag;
			end
			acs_pkg::OFS_BASE:    rmux[12:0] = q.base;
			acs_pkg::OFS_COUNT:   rmux[12:0] = q.count;
			acs_pkg::OFS_NEXT:    rmux[13:1] = 13'(q.base + {q.idx[11:0], 1'b0});
			acs_pkg::OFS_DONE:    rmux[12:0] = q.idx;
			default:              hit = 1'b0;
		endcase
		// One wait state so read data comes from a flop
		if (acc && !q.ready) begin
			d.ready = 1'b1;
			d.rdata = rmux;
			d.err   = !hit;
		end else begin
			d.ready = 1'b0;
			d.err   = 1'b0;
		end
		cfgWr = wr && (paddr == acs_pkg::OFS_CONFIG);
		if (cfgWr) begin
			d.cfg = pwdata[15:0] & acs_pkg::CFG_MASK;
		end
		if (wr && paddr == acs_pkg::OFS_OFFSET) begin
			d.offset = pwdata[15:0];
		end
		if (wr && paddr == acs_pkg::OFS_GAIN) begin
			d.gain = pwdata[15:0];
		end
		if (wr && paddr == acs_pkg::OFS_ENABLE) begin
			d.evEn = pwdata[acs_pkg::EV_MSB:acs_pkg::EV_LSB];
		end
		if (wr && paddr == acs_pkg::OFS_BASE) begin
			d.base = pwdata[12:0];
		end
		if (wr && paddr == acs_pkg::OFS_COUNT) begin
			d.count = pwdata[12:0];
		end
		if (wr && paddr == acs_pkg::OFS_STATUS) begin
			evClr = pwdata[acs_pkg::EV_MSB:acs_pkg::EV_LSB];
		end
		// Sample clock from the fixed system clock, so the oscillator choice
		// never changes timing; the fast rate is the nearest whole divide
		divLast  = q.cfg[acs_pkg::CFG_CLK] ? 5'(acs_pkg::SLOW_DIV - 1)
		                                   : 5'(acs_pkg::FAST_DIV - 1);
		tickLast = (q.tickCnt == divLast);
		convLast = 13'((acs_pkg::SMP_BASE << q.cfg[15:acs_pkg::CFG_SMP_LSB]) - 13'h0001);
		d.clkPrev = cpuClkSel;
		restart   = cfgWr || (cpuClkSel != q.clkPrev);
		// Sequencer
		case (q.seq)
			acs_pkg::SEQ_OFF: begin
				if (d.cfg[acs_pkg::CFG_EN]) begin
					d.seq     = acs_pkg::SEQ_WARM;
					d.warmCnt = 10'h000;
					d.discard = 1'b1;
				end
			end
			acs_pkg::SEQ_WARM: begin
				if (!d.cfg[acs_pkg::CFG_EN]) begin
					d.seq = acs_pkg::SEQ_OFF;
				end else if (q.warmCnt == 10'(acs_pkg::WARM_CYC - 1)) begin
					d.seq     = acs_pkg::SEQ_CONV;
					d.tickCnt = 5'h00;
					d.smpCnt  = 13'h0000;
				end else begin
					d.warmCnt = q.warmCnt + 10'h001;
				end
			end
			acs_pkg::SEQ_CONV: begin
				if (!d.cfg[acs_pkg::CFG_EN]) begin
					d.seq = acs_pkg::SEQ_OFF;
				end else if (restart) begin
					// Restart the conversion and throw its result away
					d.discard = 1'b1;
					d.tickCnt = 5'h00;
					d.smpCnt  = 13'h0000;
				end else if (tickLast) begin
					d.tickCnt = 5'h00;
					if (q.smpCnt == convLast) begin
						d.smpCnt = 13'h0000;
						convEnd  = 1'b1;
					end else begin
						d.smpCnt = q.smpCnt + 13'h0001;
					end
				end else begin
					d.tickCnt = q.tickCnt + 5'h01;
				end
			end
			default: d.seq = acs_pkg::SEQ_OFF;
		endcase
		if (convEnd) begin
			if (q.discard) begin
				d.discard = 1'b0;
			end else begin
				resRdy = 1'b1;
			end
		end
		d.done = resRdy;
		// Offset then gain, clamped to signed 16 bits
		sum    = $signed({convData[15], convData}) + $signed({q.offset[15], q.offset});
		prod   = sum * $signed({1'b0, q.gain});
		scaled = prod[33:acs_pkg::GAIN_FRAC];
		clip   = (scaled > acs_pkg::SAT_HI) || (scaled < acs_pkg::SAT_LO);
		if (scaled > acs_pkg::SAT_HI) begin
			corr = acs_pkg::CLIP_POS;
		end else if (scaled < acs_pkg::SAT_LO) begin
			corr = acs_pkg::CLIP_NEG;
		end else begin
			corr = scaled[15:0];
		end
		// Result DMA; a config write leaves it running
		halfLast = (q.count >> 1) - 13'h0001;
		idxNext  = q.idx + 13'h0001;
		if (resRdy) begin
			evSet[acs_pkg::EV_CLIP] = clip;
			if (q.dmaAct) begin
				d.wrValid = 1'b1;
				d.wrData  = corr;
				d.wrAddr  = 13'(q.base + {q.idx[11:0], 1'b0});
				d.idx     = idxNext;
				// Half flag needs a buffer of at least two samples
				if (q.count > 13'h0001 && q.idx == halfLast) begin
					evSet[acs_pkg::EV_HALF] = 1'b1;
				end
				if (idxNext >= q.count) begin
					evSet[acs_pkg::EV_FULL] = 1'b1;
					if (q.wrap) begin
						d.idx = 13'h0000;
					end else begin
						d.dmaAct = 1'b0;
					end
				end
			end else begin
				evSet[acs_pkg::EV_OVER] = 1'b1;
				d.result_overrun_flag = 1'b1;
			end
		end
		// Software control of the DMA overrides the write path
		if (wr && paddr == acs_pkg::OFS_DMA_CTL) begin
			d.wrap = pwdata[acs_pkg::DMA_WRAP];
			if (pwdata[acs_pkg::DMA_RST]) begin
				d.dmaAct = 1'b0;
				d.result_overrun_flag = 1'b0;
				d.idx    = 13'h0000;
			end else if (pwdata[acs_pkg::DMA_LOAD]) begin
				d.dmaAct = 1'b1;
				d.idx    = 13'h0000;
			end
		end
		// A new event beats a clear in the same cycle
		d.evSts = (q.evSts & ~evClr) | evSet;
	end

	// ****************************************
	// Registers
	// ****************************************
	// Single state register with constant reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q        <= '0;
			q.seq    <= acs_pkg::SEQ_OFF;
			q.cfg    <= acs_pkg::CFG_RESET;
			q.gain   <= acs_pkg::GAIN_RESET;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign pready     = q.ready;
	assign prdata     = q.rdata;
	assign pslverr    = q.err;
	assign analogOn   = (q.seq != acs_pkg::SEQ_OFF);
	assign convDone   = q.done;
	assign dmaWrValid = q.wrValid;
	assign dmaWrAddr  = q.wrAddr;
	assign dmaWrData  = q.wrData;
	assign irq        = |(q.evSts & q.evEn);
endmodule // acs_adc_control
`default_nettype wire

/* hdl/acs_pkg.sv */
`default_nettype none
package acs_pkg;
	// ****************************************
	// Register map (byte offsets)
	// ****************************************
	localparam logic [15:0] OFS_STATUS   = 16'hA810; // Event flags, write one to clear
	localparam logic [15:0] OFS_ENABLE   = 16'hA850; // Event mask
	localparam logic [15:0] OFS_CONFIG   = 16'hD004; // Converter configuration
	localparam logic [15:0] OFS_OFFSET   = 16'hD008; // Offset correction
	localparam logic [15:0] OFS_GAIN     = 16'hD00C; // Gain correction
	localparam logic [15:0] OFS_DMA_CTL  = 16'hD010; // Result DMA control
	localparam logic [15:0] OFS_DMA_STS  = 16'hD014; // Result DMA status
	localparam logic [15:0] OFS_BASE     = 16'hD018; // Buffer base pointer
	localparam logic [15:0] OFS_COUNT    = 16'hD01C; // Buffer sample count
	localparam logic [15:0] OFS_NEXT     = 16'hD020; // Next write address
	localparam logic [15:0] OFS_DONE     = 16'hD024; // Samples written
	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int EV_LSB      = 1;  // Flags occupy bits 4:1
	localparam int EV_MSB      = 4;
	localparam int EV_HALF     = 0;  // Index inside the 4-bit flag vector
	localparam int EV_FULL     = 1;
	localparam int EV_CLIP     = 2;
	localparam int EV_OVER     = 3;
	localparam int CFG_EN      = 0;  // Converter power bit
	localparam int CFG_CLK     = 2;  // 1 selects the slow sample clock
	localparam int CFG_SMP_LSB = 13; // Sample length code
	localparam int DMA_LOAD    = 0;
	localparam int DMA_WRAP    = 1;
	localparam int DMA_RST     = 4;
	localparam int STS_ACT     = 0;
	localparam int STS_OVF     = 1;
	localparam logic [15:0] CFG_RESET  = 16'h1800;
	localparam logic [15:0] CFG_MASK   = 16'hFFFD; // Bit 1 reserved
	localparam logic [15:0] GAIN_RESET = 16'h8000; // Unity gain
	localparam int GAIN_FRAC   = 15;
	localparam logic signed [18:0] SAT_HI = 19'sh03FFF * 19'sh2 + 19'sh1;
	localparam logic signed [18:0] SAT_LO = -19'sh04000 * 19'sh2;
	localparam logic [15:0] CLIP_POS   = 16'h7FFF;
	localparam logic [15:0] CLIP_NEG   = 16'h8000;
	localparam logic [12:0] SMP_BASE   = 13'h0020; // Shortest sample: 32 clocks
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ      = 25000000;
	localparam int WARM_NS     = 21000;  // Analog start-up wait
	localparam int WARM_CYC    = (WARM_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int FAST_HZ     = 6000000;
	localparam int SLOW_HZ     = 1000000;
	localparam int FAST_DIV    = CLK_HZ / FAST_HZ;
	localparam int SLOW_DIV    = CLK_HZ / SLOW_HZ;
	// ****************************************
	// Sequencer states
	// ****************************************
	typedef enum logic [1:0] {SEQ_OFF, SEQ_WARM, SEQ_CONV} acs_seq_t;
endpackage
`default_nettype wire

/* test/acs_conv_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ******************************
// Analog core stand-in
// ******************************
module acs_conv_model (
	input  wire logic        clk,
	input  wire logic        analogOn,
	input  wire logic [15:0] level,
	output logic      [15:0] convData
);
	// Changing pattern while powered down, so a stray sample never looks valid
	logic [15:0] idle_q = 16'hA5A5;
	// Flip every cycle
	always_ff @(posedge clk) idle_q <= ~idle_q;
	// Powered: the steady input level
	assign convData = analogOn ? level : idle_q;
endmodule // acs_conv_model
`default_nettype wire

/* test/acs_adc_control_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module acs_adc_control_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cpuClkSel,
	input wire logic analogOn,
	input wire logic convDone,
	input wire logic dmaWrValid,
	input wire logic irq
);
	// ******************************
	// Helper logic
	// ******************************
	// Shortest first result: 525 wait plus two 128-cycle conversions
	localparam int FIRST_MIN = 780;
	logic [9:0] onCnt_q;  // Cycles since power-up, saturating
	logic [8:0] selCnt_q; // Cycles since oscillator change, saturating
	logic       sel_q;    // Previous oscillator select
	logic       wrDone_q; // Register write completed last cycle
	// Counters saturate so long runs never wrap into a false pass
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			onCnt_q  <= 10'h000;
			selCnt_q <= 9'h1FF;
			sel_q    <= 1'b0;
			wrDone_q <= 1'b0;
		end else begin
			onCnt_q  <= !analogOn ? 10'h000 : onCnt_q + {9'h000, ~&onCnt_q};
			selCnt_q <= (cpuClkSel != sel_q) ? 9'h000 : selCnt_q + {8'h00, ~&selCnt_q};
			sel_q    <= cpuClkSel;
			wrDone_q <= psel && penable && pready && pwrite;
		end
	end
	// ******************************
	// Properties
	// ******************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence waitState; psel && penable && !pready; endsequence
	sequence quietAfter; !convDone [*8]; endsequence
	one_wait_a: assert property (waitState |=> pready)
		else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held");
	ready_cause_a: assert property (pready |-> psel && penable)
		else $error("pready without access");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	first_result_a: assert property (convDone |-> onCnt_q >= FIRST_MIN)
		else $error("first result too early");
	clock_discard_a: assert property (convDone |-> selCnt_q >= 9'd255)
		else $error("result too soon after oscillator change");
	off_quiet_a: assert property (!analogOn && !$past(analogOn) |-> !convDone)
		else $error("result while powered down");
	write_cause_a: assert property (dmaWrValid |-> convDone)
		else $error("write without result");
	result_gap_a: assert property (convDone |=> quietAfter)
		else $error("results too close");
	irq_rise_a: assert property ($rose(irq) |-> convDone || wrDone_q)
		else $error("irq rose without cause");
	irq_fall_a: assert property ($fell(irq) |-> wrDone_q)
		else $error("irq fell without write");
endmodule // acs_adc_control_asserts
bind acs_adc_control acs_adc_control_asserts u_chk (.clk(clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
	.cpuClkSel(cpuClkSel), .analogOn(analogOn), .convDone(convDone),
	.dmaWrValid(dmaWrValid), .irq(irq));
`default_nettype wire

/* test/acs_adc_control_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module acs_adc_control_tb;
	logic        clk       = 1'b0;
	logic        rst       = 1'b1;
	logic        psel      = 1'b0;
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic [15:0] paddr     = 16'h0000;
	logic [31:0] pwdata    = 32'h0;
	logic [15:0] level     = 16'h1234; // Input level seen by the core
	logic        cpuClkSel = 1'b0;
	logic        pready, pslverr, analogOn, convDone, dmaWrValid, irq, perr, wv;
	logic [31:0] prdata, r;
	logic [15:0] convData, wd;
	logic [12:0] dmaWrAddr, wa;
	logic [15:0] dmaWrData_w;      // Result word from the DMA port
	int          n;
	int          n_fail    = 0;
	int          tests_run = 0;
	// 25 MHz
	always #20 clk = ~clk;
	acs_adc_control dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.convData(convData), .cpuClkSel(cpuClkSel), .analogOn(analogOn), .convDone(convDone),
		.dmaWrValid(dmaWrValid), .dmaWrAddr(dmaWrAddr), .dmaWrData(dmaWrData_w), .irq(irq));
	acs_conv_model core (.clk(clk), .analogOn(analogOn), .level(level), .convData(convData));
	// ******************************
	// Tasks
	// ******************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One APB transfer; held until pready is sampled high
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int k;
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		r = prdata;
		perr = pslverr;
		if (k >= 20) n_fail++;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(r, exp);
	endtask
	// Cycles until a delivered result, capped at lim
	task automatic wait_done(input int lim);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (convDone !== 1'b1 && n < lim);
		wv = dmaWrValid;
		wa = dmaWrAddr;
		wd = dmaWrData_w;
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ******************************
	// Sequence
	// ******************************
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd_chk(acs_pkg::OFS_STATUS, 32'h0);
		rd_chk(acs_pkg::OFS_ENABLE, 32'h0);
		apb(1'b0, 16'hA900, 32'h0);
		chk(32'(perr), 32'h1);
		// Bit 0 kept zero; reserved upper bits set to prove they are ignored
		apb(1'b1, acs_pkg::OFS_ENABLE, 32'hFFFF_FFFE);
		rd_chk(acs_pkg::OFS_ENABLE, 32'h1E);
		apb(1'b1, acs_pkg::OFS_CONFIG, 32'h1);
		wait_done(3000);
		chk(32'(n > 770 && n < 800), 32'h1);
		wait_done(300);
		chk(32'(n), 32'd128);
		chk(32'(wv), 32'h0);
		// Polled circular-buffer setup, base kept even
		apb(1'b1, acs_pkg::OFS_DMA_CTL, 32'h10);
		apb(1'b1, acs_pkg::OFS_BASE, 32'h100);
		apb(1'b1, acs_pkg::OFS_COUNT, 32'h4);
		// Offset from a ground reading of 0xE020, gain from a full 0x4000 span
		apb(1'b1, acs_pkg::OFS_OFFSET, (32'hE020 - 32'hE000) >> 1);
		apb(1'b1, acs_pkg::OFS_GAIN, (32'h8000 * 32'h4000) / 32'h4000);
		apb(1'b1, acs_pkg::OFS_DMA_CTL, 32'h3);
		apb(1'b1, acs_pkg::OFS_STATUS, 32'h1F);
		rd_chk(acs_pkg::OFS_STATUS, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wait_done(300);
			chk(32'(wa), 32'h100 + 32'(2 * i));
			chk(32'(wd), 32'h1244);
			if (i == 1) rd_chk(acs_pkg::OFS_STATUS, 32'h2);
		end
		rd_chk(acs_pkg::OFS_STATUS, 32'h6);
		chk(32'(irq), 32'h1);
		apb(1'b1, acs_pkg::OFS_ENABLE, 32'h0);
		chk(32'(irq), 32'h0);
		apb(1'b1, acs_pkg::OFS_STATUS, 32'h1);
		rd_chk(acs_pkg::OFS_STATUS, 32'h6);
		apb(1'b1, acs_pkg::OFS_STATUS, 32'h7);
		rd_chk(acs_pkg::OFS_STATUS, 32'h0);
		// Gain near two drives both extremes
		apb(1'b1, acs_pkg::OFS_GAIN, 32'hFFFF);
		for (int j = 0; j < 2; j++) begin
			level <= j ? 16'h9000 : 16'h7000;
			wait_done(300);
			chk(32'(wd), j ? 32'h8000 : 32'h7FFF);
			apb(1'b0, acs_pkg::OFS_STATUS, 32'h0);
			chk(32'(r[3]), 32'h1);
			// Clear the clip flag so the next pass must raise it anew
			apb(1'b1, acs_pkg::OFS_STATUS, 32'h9);
		end
		apb(1'b1, acs_pkg::OFS_CONFIG, 32'h1);
		wait_done(400);
		chk(32'(n >= 250), 32'h1);
		chk(32'(wv), 32'h1);
		cpuClkSel <= 1'b1;
		wait_done(400);
		chk(32'(n >= 250), 32'h1);
		// Spacing unchanged after the oscillator switch
		wait_done(300);
		chk(32'(n), 32'd128);
		// Stop the DMA around a change to the slow sample clock
		apb(1'b1, acs_pkg::OFS_DMA_CTL, 32'h10);
		apb(1'b1, acs_pkg::OFS_CONFIG, 32'h5);
		apb(1'b1, acs_pkg::OFS_DMA_CTL, 32'h3);
		apb(1'b1, acs_pkg::OFS_STATUS, 32'h11);
		rd_chk(acs_pkg::OFS_DMA_STS, 32'h1);
		wait_done(2000);
		chk(32'(n >= 1500), 32'h1);
		// Slow clock: 32 sample clocks of 25 system clocks each
		wait_done(1000);
		chk(32'(n), 32'd800);
		apb(1'b1, acs_pkg::OFS_CONFIG, 32'h0);
		chk(32'(analogOn), 32'h0);
		wait_done(300);
		chk(32'(n), 32'd300);
		end_of_test();
	end
	// Watchdog: the run needs well under 20000 cycles
	initial begin
		#800000;
		n_fail++;
		end_of_test();
	end
endmodule // acs_adc_control_tb
`default_nettype wire
